//--- hw/sacc_buf.v
// two-entry result buffer with valid/ready on both sides
`timescale 1ns/100ps
module sacc_buf #(
  parameter WIDTH = 12
) (
  input  wire             mclk,
  input  wire             srst,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem_ff [0:1];
  reg             wrPtr_ff;
  reg             rdPtr_ff;
  reg [1:0]       count_ff;
  wire            push;
  wire            pop;

  assign inReady  = (count_ff != 2'h2); // honest full
  assign outValid = (count_ff != 2'h0); // honest empty
  assign outData  = mem_ff[rdPtr_ff];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // storage and pointers
  always @(posedge mclk) begin
    if (srst) begin
      mem_ff[0] <= {WIDTH{1'b0}};
      mem_ff[1] <= {WIDTH{1'b0}};
      wrPtr_ff  <= 1'b0;
      rdPtr_ff  <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (push) begin
        mem_ff[wrPtr_ff] <= inData;
        wrPtr_ff         <= ~wrPtr_ff;
      end
      if (pop) begin
        rdPtr_ff <= ~rdPtr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end
endmodule // sacc_buf

//--- hw/sacc_ctrl.v
// serial converter conversion control: framing, clock modes, strobe, shift-out, power-down
`timescale 1ns/100ps
`include "sacc_defines.vh"
module sacc_ctrl (
  input  wire        mclk,
  input  wire        srst,
  input  wire        sclkPin,
  input  wire        csPinN,
  input  wire        dinPin,
  input  wire        hwPowerdownPinN,
  input  wire        hwPowerdownFloat,
  input  wire        compIn,
  output wire        doutO,
  output wire        doutOe,
  output wire        convStrobeO,
  output wire        convStrobeOe,
  output wire        trackHold,
  output wire [11:0] dacCode,
  output wire [2:0]  chanSel,
  output wire        unipolar,
  output wire        singleEnded,
  output wire        analogOn,
  output wire        bandgapOn,
  output wire        compExternal,
  output wire        porBusy,
  output wire        convBusy
);
  // conversion states, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_EXT  = 4'h2;
  localparam [3:0] ST_INT  = 4'h4;
  localparam [3:0] ST_PUSH = 4'h8;
  localparam integer STEP_I    = `SACC_INT_STEP_CYC - 1;
  localparam integer POR_I     = `SACC_POR_CYC;
  localparam [4:0]   STEP_LAST = STEP_I[4:0];
  localparam [11:0]  POR_CYC   = POR_I[11:0];
  localparam [11:0]  SAR_MSB   = 12'h800;
  // synchronised pin levels
  wire        sclkLvl;
  wire        csnLvl;
  wire        dinLvl;
  wire        shdnLvl;
  wire        floatLvl;

  reg         sclkPrev_ff;
  reg         csnPrev_ff;
  reg  [3:0]  state_ff;
  reg  [7:0]  rxSr_ff;
  reg  [2:0]  rxCnt_ff;
  reg         rxActive_ff;
  reg         ctrlReady_ff;
  reg         csRefell_ff;
  reg         clkModeExt_ff;
  reg         powerModeUpper_ff;
  reg         powerModeLower_ff;
  reg  [2:0]  chanSel_ff;
  reg         unipolar_ff;
  reg         singleEnded_ff;
  reg         analogOn_ff;
  reg         bandgapOn_ff;
  reg         strobe_ff;
  reg         dout_ff;
  reg  [11:0] outSr_ff;
  reg         outFresh_ff;
  reg  [11:0] sarTrial_ff;
  reg  [11:0] sarMask_ff;
  reg  [3:0]  extCnt_ff;
  reg  [3:0]  intStep_ff;
  reg  [4:0]  tick_ff;
  reg  [11:0] porCnt_ff;

  reg  [11:0] nxt_sarTrial;
  reg  [11:0] nxt_sarMask;
  wire        sclkRise;
  wire        sclkFall;
  wire        csLow;
  wire        csFell;
  wire        hwDown;
  wire        converting;
  wire        huntOk;
  wire        useExt;
  wire        bufInReady;
  wire        bufOutValid;
  wire        bufOutReady;
  wire [11:0] bufOutData;

  sacc_sync #(.INIT(1'b0)) u_syncSclk (
    .mclk   (mclk),
    .srst   (srst),
    .pinIn  (sclkPin),
    .lvlOut (sclkLvl)
  );
  sacc_sync #(.INIT(1'b1)) u_syncCs (
    .mclk   (mclk),
    .srst   (srst),
    .pinIn  (csPinN),
    .lvlOut (csnLvl)
  );
  sacc_sync #(.INIT(1'b0)) u_syncDin (
    .mclk   (mclk),
    .srst   (srst),
    .pinIn  (dinPin),
    .lvlOut (dinLvl)
  );
  sacc_sync #(.INIT(1'b1)) u_syncShdn (
    .mclk   (mclk),
    .srst   (srst),
    .pinIn  (hwPowerdownPinN),
    .lvlOut (shdnLvl)
  );
  sacc_sync #(.INIT(1'b0)) u_syncFloat (
    .mclk   (mclk),
    .srst   (srst),
    .pinIn  (hwPowerdownFloat),
    .lvlOut (floatLvl)
  );

  // internal-mode results queue here until the shift register takes them
  sacc_buf #(.WIDTH(`SACC_RES_BITS)) u_resBuf (
    .mclk     (mclk),
    .srst     (srst),
    .inValid  (state_ff == ST_PUSH),
    .inReady  (bufInReady),
    .inData   (sarTrial_ff),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // shift-clock and chip-select edges seen on the system clock
  assign sclkRise   = sclkLvl & ~sclkPrev_ff;
  assign sclkFall   = ~sclkLvl & sclkPrev_ff;
  assign csLow      = ~csnLvl;
  assign csFell     = ~csnLvl & csnPrev_ff;
  assign hwDown     = ~shdnLvl & ~floatLvl; // driven low, not floating
  assign converting = (state_ff != ST_IDLE);
  // start bit allowed when idle, after bit five is out, or after a fresh chip select
  assign huntOk     = !converting || csRefell_ff ||
                      ((state_ff == ST_EXT) && (extCnt_ff >= `SACC_B5_CNT));
  // upper power bit set picks the clock mode, otherwise the previous mode is kept
  assign useExt     = rxSr_ff[`SACC_CB_PWR_UPPER] ? rxSr_ff[`SACC_CB_PWR_LOWER]
                                                  : clkModeExt_ff;
  // take a new result only when the last one has started shifting and no edge collides
  assign bufOutReady = ~outFresh_ff & ~sclkFall;

  // one successive-approximation decision on the comparator
  always @* begin
    nxt_sarMask  = sarMask_ff >> 1;
    nxt_sarTrial = (compIn ? sarTrial_ff : (sarTrial_ff & ~sarMask_ff)) | nxt_sarMask;
  end

  // framing, conversion sequencing, shift-out and power control
  always @(posedge mclk) begin
    if (srst) begin
      sclkPrev_ff       <= 1'b0;
      csnPrev_ff        <= 1'b1;
      state_ff          <= ST_IDLE;
      rxSr_ff           <= 8'h00;
      rxCnt_ff          <= 3'h0;
      rxActive_ff       <= 1'b0;
      ctrlReady_ff      <= 1'b0;
      csRefell_ff       <= 1'b0;
      clkModeExt_ff     <= `SACC_RST_EXTMODE;
      powerModeUpper_ff <= 1'b1;
      powerModeLower_ff <= 1'b0;
      chanSel_ff        <= 3'h0;
      unipolar_ff       <= 1'b0;
      singleEnded_ff    <= 1'b0;
      analogOn_ff       <= 1'b1;
      bandgapOn_ff      <= 1'b1;
      strobe_ff         <= `SACC_RST_STROBE;
      dout_ff           <= 1'b0;
      outSr_ff          <= `SACC_RST_SHIFT;
      outFresh_ff       <= 1'b0;
      sarTrial_ff       <= 12'h000;
      sarMask_ff        <= 12'h000;
      extCnt_ff         <= 4'h0;
      intStep_ff        <= 4'h0;
      tick_ff           <= 5'h00;
      porCnt_ff         <= POR_CYC;
    end else begin
      sclkPrev_ff <= sclkLvl;
      csnPrev_ff  <= csnLvl;
      if (porCnt_ff != 12'h000) begin
        porCnt_ff <= porCnt_ff - 12'h001;
      end
      // a new chip-select fall re-arms start-bit hunting during a conversion
      if (csFell && converting) begin
        csRefell_ff <= 1'b1;
      end
      // external mode: strobe drives low again after chip select returns
      if (csFell && clkModeExt_ff && state_ff != ST_EXT) begin
        strobe_ff <= 1'b0;
      end
      // control-byte reception on rising edges, blocked while chip select is high
      if (sclkRise && csLow && !hwDown) begin
        if (rxActive_ff) begin
          rxSr_ff  <= {rxSr_ff[6:0], dinLvl};
          rxCnt_ff <= rxCnt_ff + 3'h1;
          if (rxCnt_ff == 3'h7) begin
            rxActive_ff  <= 1'b0;
            ctrlReady_ff <= 1'b1;
          end
        end else if (huntOk && dinLvl) begin
          rxActive_ff  <= 1'b1;
          rxSr_ff      <= 8'h01;
          rxCnt_ff     <= 3'h1;
          analogOn_ff  <= 1'b1;
          bandgapOn_ff <= 1'b1;
          csRefell_ff  <= csFell & converting; // a same-cycle fall is kept
          if (converting) begin
            state_ff  <= ST_IDLE;
            strobe_ff <= clkModeExt_ff ? 1'b0 : 1'b1;
          end
        end
      end
      // falling edges: conversion start, external decisions, or result shift-out
      if (sclkFall && !hwDown) begin
        if (ctrlReady_ff) begin
          ctrlReady_ff <= 1'b0;
          chanSel_ff     <= rxSr_ff[`SACC_CB_SEL_HI:`SACC_CB_SEL_LO];
          unipolar_ff    <= rxSr_ff[`SACC_CB_UNI];
          singleEnded_ff <= rxSr_ff[`SACC_CB_SGL];
          powerModeUpper_ff <= rxSr_ff[`SACC_CB_PWR_UPPER];
          powerModeLower_ff <= rxSr_ff[`SACC_CB_PWR_LOWER];
          clkModeExt_ff  <= useExt;
          sarTrial_ff    <= SAR_MSB;
          sarMask_ff     <= SAR_MSB;
          csRefell_ff    <= csFell & converting; // a same-cycle fall is kept
          if (useExt) begin
            state_ff  <= ST_EXT;
            strobe_ff <= 1'b1;
            dout_ff   <= 1'b0;
            extCnt_ff <= 4'h0;
            outSr_ff  <= 12'h000;
          end else begin
            state_ff   <= ST_INT;
            strobe_ff  <= 1'b0;
            tick_ff    <= 5'h00;
            intStep_ff <= 4'h0;
          end
        end else if (state_ff == ST_EXT) begin
          strobe_ff   <= 1'b0;
          extCnt_ff   <= extCnt_ff + 4'h1;
          sarTrial_ff <= nxt_sarTrial;
          sarMask_ff  <= nxt_sarMask;
          dout_ff     <= compIn;
          if (extCnt_ff == `SACC_EXT_LAST - 4'h1) begin
            state_ff <= ST_IDLE;
            if (!powerModeUpper_ff) begin
              analogOn_ff  <= 1'b0;
              bandgapOn_ff <= powerModeLower_ff;
            end
          end
        end else if (csLow) begin
          dout_ff     <= outSr_ff[11];
          outSr_ff    <= {outSr_ff[10:0], 1'b0};
          outFresh_ff <= 1'b0;
        end
      end
      // internal conversion runs on its own tick, regardless of chip select
      if (state_ff == ST_INT && !hwDown) begin
        if (tick_ff == STEP_LAST) begin
          tick_ff     <= 5'h00;
          sarTrial_ff <= nxt_sarTrial;
          sarMask_ff  <= nxt_sarMask;
          intStep_ff  <= intStep_ff + 4'h1;
          if (intStep_ff == `SACC_EXT_LAST - 4'h1) begin
            state_ff <= ST_PUSH;
          end
        end else begin
          tick_ff <= tick_ff + 5'h01;
        end
      end
      // result into the buffer; strobe rises when it is held
      if (state_ff == ST_PUSH && bufInReady && !hwDown) begin
        state_ff  <= ST_IDLE;
        strobe_ff <= 1'b1;
        if (!powerModeUpper_ff) begin
          analogOn_ff  <= 1'b0;
          bandgapOn_ff <= powerModeLower_ff;
        end
      end
      // load the next held result for shifting
      if (bufOutValid && bufOutReady) begin
        outSr_ff    <= bufOutData;
        outFresh_ff <= 1'b1;
      end
      // hardware shutdown abandons conversion and control-byte reception at once; held results stay queued
      if (hwDown) begin
        state_ff     <= ST_IDLE;
        rxActive_ff  <= 1'b0;
        ctrlReady_ff <= 1'b0;
        analogOn_ff  <= 1'b0;
        bandgapOn_ff <= 1'b0;
        if (!clkModeExt_ff) begin
          strobe_ff <= 1'b1;
        end
      end
    end
  end

  // pad drives: data floats with chip select high; strobe only floats in external mode
  assign doutO        = dout_ff;
  assign doutOe       = csLow;
  assign convStrobeO  = strobe_ff;
  assign convStrobeOe = clkModeExt_ff ? csLow : 1'b1;
  assign trackHold    = rxActive_ff && (rxCnt_ff >= `SACC_ACQ_CNT);
  assign dacCode      = sarTrial_ff;
  assign chanSel      = chanSel_ff;
  assign unipolar     = unipolar_ff;
  assign singleEnded  = singleEnded_ff;
  assign analogOn     = analogOn_ff;
  assign bandgapOn    = bandgapOn_ff;
  assign compExternal = floatLvl;
  assign porBusy      = (porCnt_ff != 12'h000);
  assign convBusy     = converting;
endmodule // sacc_ctrl

//--- hw/sacc_defines.vh
// timing counts, control-byte field positions and reset values for the converter control
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH

// system clock period in ns (25 MHz)
`define SACC_SYS_NS        40
// longest internal conversion, in us, and its cycle count (rounded down)
`define SACC_INT_MAX_US    10
`define SACC_INT_MAX_CYC   ((`SACC_INT_MAX_US * 1000) / `SACC_SYS_NS)
// internal conversion uses 13 slots: 12 decisions plus margin
`define SACC_INT_SLOTS     13
`define SACC_INT_STEP_CYC  (`SACC_INT_MAX_CYC / `SACC_INT_SLOTS)
// power-on internal reset time in us and its cycle count (rounded up)
`define SACC_POR_US        100
`define SACC_POR_CYC       ((`SACC_POR_US * 1000 + `SACC_SYS_NS - 1) / `SACC_SYS_NS)

// control-byte field positions
`define SACC_CB_START      7
`define SACC_CB_SEL_HI     6
`define SACC_CB_SEL_LO     4
`define SACC_CB_UNI        3
`define SACC_CB_SGL        2
`define SACC_CB_PWR_UPPER  1
`define SACC_CB_PWR_LOWER  0

// result width, last decision count, count at which result bit five is out
`define SACC_RES_BITS      12
`define SACC_EXT_LAST      4'hc
`define SACC_B5_CNT        4'h7
// control-byte bit count at which the last three bits start arriving
`define SACC_ACQ_CNT       3'h5

// reset values
`define SACC_RST_STROBE    1'b1
`define SACC_RST_EXTMODE   1'b0
`define SACC_RST_SHIFT     12'h000

`endif

//--- hw/sacc_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module sacc_sync #(
  parameter INIT = 1'b0
) (
  input  wire mclk,
  input  wire srst,
  input  wire pinIn,
  output wire lvlOut
);
  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg level_ff;

  // first stage feeds only the second; the level moves once stages two and three agree
  always @(posedge mclk) begin
    if (srst) begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
      stage3_ff <= INIT;
      level_ff  <= INIT;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff) begin
        level_ff <= stage3_ff;
      end
    end
  end

  assign lvlOut = level_ff;
endmodule // sacc_sync

//--- test/sacc_ctrl_props.sv
// concurrent checks on the converter control ports
`timescale 1ns/100ps
module sacc_ctrl_props (
  input wire mclk,
  input wire srst,
  input wire csPinN,
  input wire hwPowerdownPinN,
  input wire hwPowerdownFloat,
  input wire doutO,
  input wire doutOe,
  input wire convStrobeO,
  input wire convStrobeOe,
  input wire trackHold,
  input wire analogOn,
  input wire compExternal,
  input wire porBusy,
  input wire convBusy
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);
  // power-on phase: strobe high and driven, nothing converts, zeros out
  property p_por_strb; porBusy |-> convStrobeO && convStrobeOe; endproperty
  property p_por_zero; porBusy |-> !convBusy && !doutO; endproperty
  // released chip select floats the data output; strobe never floats alone
  property p_cs_float; csPinN [*8] |-> !doutOe; endproperty
  property p_oe_pair; !convStrobeOe |-> !doutOe; endproperty
  // shutdown pin forces power-down and abandons work; floating pin picks compensation
  property p_hw_powerdown_pin; (!hwPowerdownFloat && !hwPowerdownPinN) [*8] |-> !analogOn && !convBusy;
  endproperty
  property p_comp; $rose(hwPowerdownFloat) |-> ##[0:6] compExternal; endproperty
  // acquisition ends into a conversion, which needs power
  property p_track; $fell(trackHold) |-> ##[0:12] convBusy; endproperty
  property p_pwr; convBusy |-> analogOn; endproperty
  a_por_strb: assert property (p_por_strb) else $error("por strobe");
  a_por_zero: assert property (p_por_zero) else $error("por output");
  a_cs_float: assert property (p_cs_float) else $error("dout float");
  a_oe_pair: assert property (p_oe_pair) else $error("enable pair");
  a_hw_powerdown_pin: assert property (p_hw_powerdown_pin) else $error("shutdown");
  a_comp: assert property (p_comp) else $error("compensation");
  a_track: assert property (p_track) else $error("track to convert");
  a_pwr: assert property (p_pwr) else $error("convert unpowered");
  c_pulse: cover property ($rose(convStrobeO) ##[1:12] $fell(convStrobeO));
  c_track: cover property ($fell(trackHold));
  c_hw_powerdown_pin: cover property ($fell(analogOn));
endmodule // sacc_ctrl_props

bind sacc_ctrl sacc_ctrl_props sacc_ctrl_props_inst (
  .mclk(mclk), .srst(srst), .csPinN(csPinN), .hwPowerdownPinN(hwPowerdownPinN),
  .hwPowerdownFloat(hwPowerdownFloat), .doutO(doutO), .doutOe(doutOe),
  .convStrobeO(convStrobeO), .convStrobeOe(convStrobeOe), .trackHold(trackHold),
  .analogOn(analogOn), .compExternal(compExternal), .porBusy(porBusy), .convBusy(convBusy)
);

//--- test/sacc_host.sv
// host serial port model: clock master for chip select, shift clock and data in
`timescale 1ns/100ps
module sacc_host (
  input  wire mclk,
  input  wire doutO,
  input  wire convStrobeO,
  output reg  sclkPin,
  output reg  csPinN,
  output reg  dinPin
);
  // idle: clock parked low, device deselected
  initial begin
    sclkPin = 1'b0;
    csPinN = 1'b1;
    dinPin = 1'b0;
  end
  // select or release; a released data line flips so no stale level is seen
  task sel(input reg on);
    begin
      @(posedge mclk);
      csPinN <= !on;
      if (!on) dinPin <= !dinPin;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  // one byte, msb first: data set with the falling clock, read late in the high phase
  task xfer(input reg [7:0] tx, output reg [7:0] rx, output reg [7:0] stb);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        @(posedge mclk);
        sclkPin <= 1'b0;
        dinPin <= tx[i];
        repeat (4) @(posedge mclk);
        sclkPin <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rx[i] = doutO;
        stb[i] = convStrobeO;
      end
      @(posedge mclk);
      sclkPin <= 1'b0;
    end
  endtask
endmodule // sacc_host

//--- test/sacc_tb.sv
// self-checking bench: host model, comparator model and scenario tasks
`timescale 1ns/100ps
module testbench;
  reg         mclk;
  reg         srst;
  reg         hwPowerdownPinN;
  reg         hwPowerdownFloat;
  reg         compIn;
  reg  [11:0] vin;
  reg  [7:0]  rx;
  reg  [7:0]  stb;
  integer     failures;
  integer     checks;
  integer     n;
  integer     p;
  wire        sclkPin;
  wire        csPinN;
  wire        dinPin;
  wire        doutO;
  wire        doutOe;
  wire        convStrobeO;
  wire        convStrobeOe;
  wire [11:0] dacCode;
  wire [2:0]  chanSel;
  wire        analogOn;
  wire        bandgapOn;
  wire        compExternal;
  wire        porBusy;
  wire        convBusy;
  wire        unipolar;
  wire        singleEnded;
  // released lines show the inverse of the last level, so a missing drive is seen
  wire        doutLine = doutOe ? doutO : !doutO;
  wire        strbLine = convStrobeOe ? convStrobeO : !convStrobeO;

  // clock; comparator keeps the trial bit while the trial code is not above the input
  always #20 mclk = !mclk;
  always @(posedge mclk) compIn <= (dacCode <= vin);

  sacc_ctrl sacc_ctrl_inst (.mclk(mclk), .srst(srst), .sclkPin(sclkPin), .csPinN(csPinN),
    .dinPin(dinPin), .hwPowerdownPinN(hwPowerdownPinN), .hwPowerdownFloat(hwPowerdownFloat),
    .compIn(compIn), .doutO(doutO), .doutOe(doutOe), .convStrobeO(convStrobeO),
    .convStrobeOe(convStrobeOe), .trackHold(), .dacCode(dacCode), .chanSel(chanSel),
    .unipolar(unipolar), .singleEnded(singleEnded), .analogOn(analogOn), .bandgapOn(bandgapOn),
    .compExternal(compExternal), .porBusy(porBusy), .convBusy(convBusy));
  sacc_host sacc_host_inst (.mclk(mclk), .doutO(doutLine), .convStrobeO(strbLine),
    .sclkPin(sclkPin), .csPinN(csPinN), .dinPin(dinPin));

  task report_and_stop;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [11:0] e, input [11:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // wait k rising edges, then settle to the falling edge for sampling
  task tick(input integer k);
    begin
      repeat (k) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  // external-clock conversion: control byte, then two read bytes
  task extConv(input [7:0] cb, input [11:0] v);
    begin
      vin = v;
      sacc_host_inst.xfer(cb, rx, stb);
      sacc_host_inst.xfer(8'h00, rx, stb);
      chk("rb2", {5'h00, v[11:5]}, {4'h0, rx});
      chk("strobe bits", 12'h080, {4'h0, stb});
      sacc_host_inst.xfer(8'h00, rx, stb);
      chk("rb3", {4'h0, v[4:0], 3'h0}, {4'h0, rx});
    end
  endtask
  // internal-clock conversion with chip select released while it runs
  task intConv(input [7:0] cb, input [11:0] v);
    begin
      vin = v;
      sacc_host_inst.xfer(cb, rx, stb);
      sacc_host_inst.sel(1'b0);
      chk("strobe", 12'h000, {11'h0, convStrobeO});
      chk("strobe oe", 12'h001, {11'h0, convStrobeOe});
      n = 0;
      while (convStrobeO !== 1'b1 && n < 400) begin
        tick(1);
        n = n + 1;
      end
      chk("strobe low time", 12'h001, {11'h0, n < 250});
      if (n == 400) report_and_stop;
      sacc_host_inst.sel(1'b1);
      sacc_host_inst.xfer(8'h00, rx, stb);
      chk("rb2", {5'h00, v[11:5]}, {5'h00, rx[6:0]});
      sacc_host_inst.xfer(8'h00, rx, stb);
      chk("rb3", {4'h0, v[4:0], 3'h0}, {4'h0, rx});
    end
  endtask
  task t_por;
    begin
      chk("strobe", 12'h001, {11'h0, convStrobeO});
      chk("strobe oe", 12'h001, {11'h0, convStrobeOe});
      n = 0;
      while (porBusy !== 1'b0 && n < 3000) begin
        tick(1);
        n = n + 1;
      end
      chk("por time", 12'h001, {11'h0, n > 2400 && n < 3000});
      if (n == 3000) report_and_stop;
      sacc_host_inst.sel(1'b1);
      sacc_host_inst.xfer(8'h00, rx, stb);
      chk("dout", 12'h000, {4'h0, rx});
      $display("test por done");
    end
  endtask
  task t_ext;
    begin
      sacc_host_inst.xfer(8'h00, rx, stb);
      extConv(8'hcf, 12'ha5c);
      chk("channel", 12'h004, {9'h0, chanSel});
      chk("uni sgl", 12'h003, {10'h0, unipolar, singleEnded});
      sacc_host_inst.sel(1'b0);
      chk("dout oe", 12'h000, {11'h0, doutOe});
      chk("strobe oe", 12'h000, {11'h0, convStrobeOe});
      sacc_host_inst.sel(1'b1);
      chk("strobe oe", 12'h001, {11'h0, convStrobeOe});
      chk("strobe", 12'h000, {11'h0, convStrobeO});
      // a fresh chip select during a conversion lets a new start bit restart it
      sacc_host_inst.xfer(8'hcf, rx, stb);
      sacc_host_inst.sel(1'b0);
      sacc_host_inst.sel(1'b1);
      extConv(8'hb3, 12'h5a3);
      chk("channel", 12'h003, {9'h0, chanSel});
      chk("uni sgl", 12'h000, {10'h0, unipolar, singleEnded});
      $display("test ext done");
    end
  endtask
  task t_int;
    begin
      intConv(8'h8e, 12'h3c1);
      $display("test int done");
    end
  endtask
  // software power-down codes keep the internal clock for each conversion
  task t_pd;
    begin
      for (p = 0; p < 2; p = p + 1) begin
        intConv(8'hac + p[7:0], 12'h9b6 - p[11:0]);
        chk("analog on", 12'h000, {11'h0, analogOn});
        chk("bandgap on", p[11:0], {11'h0, bandgapOn});
      end
      $display("test powerdown done");
    end
  endtask
  task t_hw_powerdown_pin;
    begin
      vin = 12'h7ff;
      sacc_host_inst.xfer(8'h8f, rx, stb);
      chk("analog on", 12'h001, {11'h0, analogOn});
      @(posedge mclk);
      hwPowerdownPinN <= 1'b0;
      tick(10);
      chk("analog off", 12'h000, {11'h0, analogOn});
      chk("busy", 12'h000, {11'h0, convBusy});
      @(posedge mclk);
      hwPowerdownPinN <= 1'b1;
      hwPowerdownFloat <= 1'b1;
      tick(10);
      chk("comp ext", 12'h001, {11'h0, compExternal});
      @(posedge mclk);
      hwPowerdownFloat <= 1'b0;
      tick(10);
      extConv(8'h8f, 12'h123);
      $display("test shutdown done");
    end
  endtask
  // reset, then the scenarios in order
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    hwPowerdownPinN = 1'b1;
    hwPowerdownFloat = 1'b0;
    vin = 12'h000;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    tick(1);
    t_por;
    t_ext;
    t_int;
    t_pd;
    t_hw_powerdown_pin;
    report_and_stop;
  end
endmodule // testbench
